// File: common/ivm_pkg.sv
// constants, vector table and carrier types of the interrupt vector mapper
// assumes event sources are one-cycle pulses on the system clock
package ivm_pkg;

   // ----------------------------------------------------------------
   // vector table
   // ----------------------------------------------------------------
   localparam int VEC_COUNT                        = 37;
   localparam int PAD_W                            = 64 - VEC_COUNT;
   localparam int RESET_VECTOR                     = 0;
   localparam int NMI_VECTOR                       = 1;
   localparam int SUPPLY_LEVEL_MONITOR_VECTOR      = 2;
   localparam int CLOCK_FAILURE_VECTOR             = 3;
   localparam int MULTI_VOLTAGE_IO_VECTOR          = 4;
   localparam int REALTIME_COUNTER_MATCH_VECTOR    = 5;
   localparam int REALTIME_PERIODIC_VECTOR         = 6;
   localparam int CUSTOM_LOGIC_VECTOR              = 7;
   localparam int PIN_BANK_A_VECTOR                = 8;
   localparam int TIMER_A_OVERFLOW_VECTOR          = 9;
   localparam int TIMER_A_HIGH_UNDERFLOW_VECTOR    = 10;
   localparam int TIMER_A_COMPARE_TWO_VECTOR       = 13;
   localparam int TIMER_B0_CAPTURE_VECTOR          = 14;
   localparam int TIMER_B1_CAPTURE_VECTOR          = 15;
   localparam int TIMER_D_OVERFLOW_VECTOR          = 16;
   localparam int TIMER_D_TRIGGER_VECTOR           = 17;
   localparam int TWO_WIRE_CLIENT_VECTOR           = 18;
   localparam int TWO_WIRE_HOST_VECTOR             = 19;
   localparam int SERIAL_PERIPHERAL_VECTOR         = 20;
   localparam int SERIAL_PORT0_RECEIVE_COMPLETE    = 21;
   localparam int PIN_BANK_D_VECTOR                = 24;
   localparam int COMPARATOR0_VECTOR               = 25;
   localparam int CONVERTER_RESULT_READY_VECTOR    = 26;
   localparam int CONVERTER_WINDOW_COMPARE_VECTOR  = 27;
   localparam int ZERO_CROSS_VECTOR                = 28;
   localparam int COMPARATOR1_VECTOR               = 29;
   localparam int PIN_BANK_C_VECTOR                = 30;
   localparam int TIMER_B2_CAPTURE_VECTOR          = 31;
   localparam int SERIAL_PORT1_RECEIVE_COMPLETE    = 32;
   localparam int PIN_BANK_F_VECTOR                = 35;
   localparam int EEPROM_READY_VECTOR              = 36;
   localparam logic [7:0] VEC_ADDR_STEP            = 8'h02;
   localparam logic [36:0] NMI_ONLY                = 37'h0_0000_0002;

   // ----------------------------------------------------------------
   // register map (byte offsets) and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] FLAG_LO_OFS = 8'h00;
   localparam logic [7:0] FLAG_HI_OFS = 8'h04;
   localparam logic [7:0] EN_LO_OFS   = 8'h08;
   localparam logic [7:0] EN_HI_OFS   = 8'h0C;
   localparam logic [7:0] CTRL_OFS    = 8'h10;
   localparam logic [7:0] PEND_LO_OFS = 8'h14;
   localparam logic [7:0] PEND_HI_OFS = 8'h18;
   localparam logic [7:0] VECT_OFS    = 8'h1C;
   localparam int CTRL_GLOBAL_BIT     = 0;
   localparam int CTRL_SPLIT_BIT      = 1;
   localparam int CTRL_CLKNMI_BIT     = 2;
   localparam logic [36:0] FLAG_RST   = 37'h0_0000_0000;
   localparam logic [36:0] EN_RST     = 37'h0_0000_0000;
   localparam logic [31:0] UNMAPPED   = 32'h0000_0000;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        memScan;
      logic        clkFail;
      logic [4:0]  timerASplit;
      logic [36:0] vecEvent;
   } ivm_src_type;

endpackage : ivm_pkg

// File: verilog/ivm_top.sv
// interrupt vector mapper: flags, enables, requests and vector pick
// assumes Avalon-MM master on the same clock, sources pulse on clock
`timescale 1ns/1ps
module ivm_top (
   input  wire logic                 clock,
   input  wire logic                 rst,
   input  wire logic [7:0]           address,
   input  wire logic                 read,
   input  wire logic                 write,
   input  wire logic [31:0]          writedata,
   input  wire logic [3:0]           byteenable,
   output logic      [31:0]          readdata,
   output logic                      waitrequest,
   input  wire ivm_pkg::ivm_src_type src,
   output logic      [36:0]          reqVec,
   output logic                      irq,
   output logic                      nmi,
   output logic      [7:0]           vecNum,
   output logic      [7:0]           vecAddr,
   output logic                      vecValid
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [36:0] flag_r;
   logic [36:0] flag_nxt;
   logic [36:0] enable_r;
   logic [36:0] enable_nxt;
   logic [36:0] reqVec_r;
   logic [36:0] reqVec_nxt;
   logic        globalEn_r;
   logic        split_r;
   logic        clkFailToNmi_r;
   logic        irq_r;
   logic        nmi_r;
   logic [7:0]  vecNum_r;
   logic [7:0]  vecNum_nxt;
   logic [7:0]  vecAddr_r;
   logic        vecValid_r;
   logic [31:0] readdata_r;
   logic [31:0] readdata_nxt;
   logic        waitrequest_r;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   wire         busReq   = read | write;
   wire         wrFire   = write & ~waitrequest_r;
   wire         selFlagLo = address == ivm_pkg::FLAG_LO_OFS;
   wire         selFlagHi = address == ivm_pkg::FLAG_HI_OFS;
   wire         selEnLo   = address == ivm_pkg::EN_LO_OFS;
   wire         selEnHi   = address == ivm_pkg::EN_HI_OFS;
   wire         selCtrl   = address == ivm_pkg::CTRL_OFS;
   wire         selPendLo = address == ivm_pkg::PEND_LO_OFS;
   wire         selPendHi = address == ivm_pkg::PEND_HI_OFS;
   wire         selVect   = address == ivm_pkg::VECT_OFS;
   wire [31:0]  beMask   = {{8{byteenable[3]}}, {8{byteenable[2]}},
                            {8{byteenable[1]}}, {8{byteenable[0]}}};
   wire [31:0]  wdMasked = writedata & beMask;
   wire [31:0]  zero32   = 32'h0000_0000;

   // ----------------------------------------------------------------
   // write-one-to-clear of flags, masked enable writes
   // ----------------------------------------------------------------
   wire [63:0]  clrWide  = {(wrFire & selFlagHi) ? wdMasked : zero32,
                            (wrFire & selFlagLo) ? wdMasked : zero32};
   wire [36:0]  clrBits  = clrWide[36:0];
   wire [63:0]  enMask   = {(wrFire & selEnHi) ? beMask : zero32,
                            (wrFire & selEnLo) ? beMask : zero32};
   wire [63:0]  enWide   = {{ivm_pkg::PAD_W{1'b0}}, enable_r};
   wire [63:0]  enNew    = (enWide & ~enMask)
                         | ({writedata, writedata} & enMask);
   wire         ctrlWr   = wrFire & selCtrl & byteenable[0];
   logic [36:0] setBit;

   assign enable_nxt = enNew[36:0];
   // set wins over a clear in the same cycle
   assign flag_nxt   = (flag_r & ~clrBits) | setBit;

   // ----------------------------------------------------------------
   // per-vector source routing and request gating
   // ----------------------------------------------------------------
   genvar gv;
   generate
      for (gv = 0; gv < ivm_pkg::VEC_COUNT; gv++) begin : g_vec
         if (gv == ivm_pkg::RESET_VECTOR) begin : g_rst
            // reset entry carries no flag
            assign setBit[gv] = 1'b0;
         end else if (gv == ivm_pkg::NMI_VECTOR) begin : g_nmi
            assign setBit[gv] = src.memScan
                              | (src.clkFail & clkFailToNmi_r);
         end else if (gv == ivm_pkg::CLOCK_FAILURE_VECTOR) begin : g_cf
            assign setBit[gv] = src.clkFail & ~clkFailToNmi_r;
         end else if (gv >= ivm_pkg::TIMER_A_OVERFLOW_VECTOR &&
                      gv <= ivm_pkg::TIMER_A_COMPARE_TWO_VECTOR) begin : g_ta
            if (gv == ivm_pkg::TIMER_A_HIGH_UNDERFLOW_VECTOR) begin : g_hu
               // unused in normal mode
               assign setBit[gv] = split_r &
                  src.timerASplit[gv - ivm_pkg::TIMER_A_OVERFLOW_VECTOR];
            end else begin : g_nm
               assign setBit[gv] = split_r
                  ? src.timerASplit[gv - ivm_pkg::TIMER_A_OVERFLOW_VECTOR]
                  : src.vecEvent[gv];
            end
         end else begin : g_dir
            // one source line per vector
            assign setBit[gv] = src.vecEvent[gv];
         end
         if (gv == ivm_pkg::NMI_VECTOR) begin : g_rq_nmi
            assign reqVec_nxt[gv] = flag_r[gv];
         end else if (gv == ivm_pkg::RESET_VECTOR) begin : g_rq_rst
            assign reqVec_nxt[gv] = 1'b0;
         end else begin : g_rq
            assign reqVec_nxt[gv] = flag_r[gv] & enable_r[gv]
                                  & globalEn_r;
         end
      end
   endgenerate
   // remaining table entries are direct lines too

   // ----------------------------------------------------------------
   // vector pick: lowest pending vector number wins
   // ----------------------------------------------------------------
   wire [36:0] maskedReq = reqVec_nxt & ~ivm_pkg::NMI_ONLY;
   wire        anyReq    = |reqVec_nxt;

   always_comb begin
      vecNum_nxt = 8'h00;
      for (int i = ivm_pkg::VEC_COUNT - 1; i > 0; i--) begin
         if (reqVec_nxt[i]) begin
            vecNum_nxt = 8'(i);
         end
      end
   end

   wire [7:0] vecAddrNxt = vecNum_nxt * ivm_pkg::VEC_ADDR_STEP;

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   wire [63:0] flagWide = {{ivm_pkg::PAD_W{1'b0}}, flag_r};
   wire [63:0] pendWide = {{ivm_pkg::PAD_W{1'b0}}, reqVec_r};
   wire [31:0] ctrlWord = {29'h0000_0000, clkFailToNmi_r, split_r,
                           globalEn_r};
   wire [31:0] vectWord = {vecValid_r, 15'h0000, vecAddr_r, vecNum_r};

   assign readdata_nxt = selFlagLo ? flagWide[31:0]
                       : selFlagHi ? flagWide[63:32]
                       : selEnLo   ? enWide[31:0]
                       : selEnHi   ? enWide[63:32]
                       : selCtrl   ? ctrlWord
                       : selPendLo ? pendWide[31:0]
                       : selPendHi ? pendWide[63:32]
                       : selVect   ? vectWord
                       : ivm_pkg::UNMAPPED;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         waitrequest_r <= 1'b1;
         readdata_r    <= 32'h0000_0000;
      end else begin
         // one wait cycle, then release for one cycle
         waitrequest_r <= ~(busReq & waitrequest_r);
         if (read & waitrequest_r) begin
            readdata_r <= readdata_nxt;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         flag_r   <= ivm_pkg::FLAG_RST;
         enable_r <= ivm_pkg::EN_RST;
      end else begin
         flag_r   <= flag_nxt;
         enable_r <= enable_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         globalEn_r     <= 1'b0;
         split_r        <= 1'b0;
         clkFailToNmi_r <= 1'b0;
      end else if (ctrlWr) begin
         globalEn_r     <= writedata[ivm_pkg::CTRL_GLOBAL_BIT];
         split_r        <= writedata[ivm_pkg::CTRL_SPLIT_BIT];
         clkFailToNmi_r <= writedata[ivm_pkg::CTRL_CLKNMI_BIT];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         reqVec_r   <= 37'h0_0000_0000;
         irq_r      <= 1'b0;
         nmi_r      <= 1'b0;
         vecNum_r   <= 8'h00;
         vecAddr_r  <= 8'h00;
         vecValid_r <= 1'b0;
      end else begin
         reqVec_r   <= reqVec_nxt;
         irq_r      <= |maskedReq;
         nmi_r      <= reqVec_nxt[ivm_pkg::NMI_VECTOR];
         vecNum_r   <= vecNum_nxt;
         vecAddr_r  <= vecAddrNxt;
         vecValid_r <= anyReq;
      end
   end

   assign readdata    = readdata_r;
   assign waitrequest = waitrequest_r;
   assign reqVec      = reqVec_r;
   assign irq         = irq_r;
   assign nmi         = nmi_r;
   assign vecNum      = vecNum_r;
   assign vecAddr     = vecAddr_r;
   assign vecValid    = vecValid_r;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_flagSetAnyway;
      @(posedge clock) disable iff (rst)
      src.vecEvent[ivm_pkg::SUPPLY_LEVEL_MONITOR_VECTOR]
      |=> flag_r[ivm_pkg::SUPPLY_LEVEL_MONITOR_VECTOR];
   endproperty
   a_flagSetAnyway: assert property (p_flagSetAnyway)
      else $error("flag not set by event");

   property p_reqNeedsEnable;
      @(posedge clock) disable iff (rst)
      reqVec_r[ivm_pkg::EEPROM_READY_VECTOR]
      |-> $past(enable_r[ivm_pkg::EEPROM_READY_VECTOR])
          && $past(flag_r[ivm_pkg::EEPROM_READY_VECTOR]);
   endproperty
   a_reqNeedsEnable: assert property (p_reqNeedsEnable)
      else $error("request without enable and flag");

   property p_globalGate;
      @(posedge clock) disable iff (rst)
      !globalEn_r |=> (reqVec_r & ~ivm_pkg::NMI_ONLY) == 37'h0_0000_0000
                      && !irq_r;
   endproperty
   a_globalGate: assert property (p_globalGate)
      else $error("maskable request while globally disabled");

   property p_reqHolds;
      @(posedge clock) disable iff (rst)
      reqVec_r[ivm_pkg::REALTIME_COUNTER_MATCH_VECTOR] && globalEn_r
      && flag_r[ivm_pkg::REALTIME_COUNTER_MATCH_VECTOR]
      && enable_r[ivm_pkg::REALTIME_COUNTER_MATCH_VECTOR] && !wrFire
      |=> reqVec_r[ivm_pkg::REALTIME_COUNTER_MATCH_VECTOR];
   endproperty
   a_reqHolds: assert property (p_reqHolds)
      else $error("request dropped before flag clear");

   property p_w1cClears;
      @(posedge clock) disable iff (rst)
      wrFire && selFlagLo && writedata[ivm_pkg::PIN_BANK_A_VECTOR]
      && byteenable[1] && !setBit[ivm_pkg::PIN_BANK_A_VECTOR]
      |=> !flag_r[ivm_pkg::PIN_BANK_A_VECTOR];
   endproperty
   a_w1cClears: assert property (p_w1cClears)
      else $error("write one did not clear flag");

   property p_nmiPath;
      @(posedge clock) disable iff (rst)
      src.memScan |-> ##2 nmi_r;
   endproperty
   a_nmiPath: assert property (p_nmiPath)
      else $error("memory scan event did not raise nmi");

   property p_clkFailRoute;
      @(posedge clock) disable iff (rst)
      src.clkFail && !clkFailToNmi_r
      |=> flag_r[ivm_pkg::CLOCK_FAILURE_VECTOR];
   endproperty
   a_clkFailRoute: assert property (p_clkFailRoute)
      else $error("clock failure missed its vector");

   property p_splitMap;
      @(posedge clock) disable iff (rst)
      split_r && src.timerASplit[1]
      |=> flag_r[ivm_pkg::TIMER_A_HIGH_UNDERFLOW_VECTOR];
   endproperty
   a_splitMap: assert property (p_splitMap)
      else $error("split high underflow not mapped");

   property p_unusedNormal;
      @(posedge clock) disable iff (rst)
      !split_r && !flag_r[ivm_pkg::TIMER_A_HIGH_UNDERFLOW_VECTOR]
      |=> !flag_r[ivm_pkg::TIMER_A_HIGH_UNDERFLOW_VECTOR];
   endproperty
   a_unusedNormal: assert property (p_unusedNormal)
      else $error("unused timer vector set in normal mode");

   property p_vecAddr;
      @(posedge clock) disable iff (rst)
      vecValid_r |-> vecAddr_r == {vecNum_r[6:0], 1'b0}
                     && vecNum_r != 8'h00;
   endproperty
   a_vecAddr: assert property (p_vecAddr)
      else $error("vector address not twice vector number");

   property p_busAnswer;
      @(posedge clock) disable iff (rst)
      busReq && waitrequest_r |=> !waitrequest_r ##1 waitrequest_r;
   endproperty
   a_busAnswer: assert property (p_busAnswer)
      else $error("bus answer not after one wait cycle");

   c_nmi: cover property (@(posedge clock) disable iff (rst)
      src.memScan ##2 nmi_r);
   c_split: cover property (@(posedge clock) disable iff (rst)
      split_r && src.timerASplit[4] ##2 reqVec_r[13]);
   c_irqTop: cover property (@(posedge clock) disable iff (rst)
      irq_r && vecNum_r == 8'h24);
   c_clearRace: cover property (@(posedge clock) disable iff (rst)
      wrFire && selFlagHi && (clrBits & setBit) != 37'h0_0000_0000);

endmodule : ivm_top

// File: test/ivm_cpu_model.sv
// cpu-side consumer of the mapper: latches offered handler words
// assumes registered vector outputs on the same clock
`timescale 1ns/1ps
module ivm_cpu_model (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       irq,
   input  wire logic       nmi,
   input  wire logic [7:0] vecAddr,
   input  wire logic       vecValid,
   output logic      [7:0] fetchAddr,
   output int              fetches
);
   // ----------------------------------------------------------------
   // handler fetch
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         fetchAddr <= 8'h00;
         fetches   <= 0;
      end else if (vecValid && (irq || nmi)) begin
         fetchAddr <= vecAddr;
         fetches   <= fetches + 1;
      end
   end
endmodule : ivm_cpu_model

// File: test/ivm_top_test.sv
// self-checking bench of the vector mapper against a behavioural model
// assumes ivm_pkg, ivm_top and ivm_cpu_model compiled before it
`timescale 1ns/1ps
module ivm_top_test;
   logic                 clock;
   logic                 rst;
   logic [7:0]           address;
   logic                 read;
   logic                 write;
   logic [31:0]          writedata;
   logic [3:0]           byteenable;
   logic [31:0]          readdata;
   logic                 waitrequest;
   ivm_pkg::ivm_src_type src;
   logic [36:0]          reqVec;
   logic                 irq;
   logic                 nmi;
   logic [7:0]           vecNum;
   logic [7:0]           vecAddr;
   logic                 vecValid;
   logic [7:0]           fetchAddr;
   int                   fetches;
   logic [36:0]          mFlag;
   logic [36:0]          mEn;
   logic [2:0]           mCtrl;
   int                   numErrors = 0;
   int                   checks = 0;

   ivm_top i_ivm_top (.clock(clock), .rst(rst), .address(address),
      .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .src(src), .reqVec(reqVec), .irq(irq),
      .nmi(nmi), .vecNum(vecNum), .vecAddr(vecAddr), .vecValid(vecValid));
   ivm_cpu_model i_ivm_cpu_model (.clock(clock), .rst(rst), .irq(irq),
      .nmi(nmi), .vecAddr(vecAddr), .vecValid(vecValid),
      .fetchAddr(fetchAddr), .fetches(fetches));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // ----------------------------------------------------------------
   // model
   // ----------------------------------------------------------------
   function automatic logic [36:0] expReq();
      logic [36:0] r;
      r    = mFlag & mEn & {37{mCtrl[0]}};
      r[1] = mFlag[1];
      r[0] = 1'b0;
      return r;
   endfunction : expReq

   function automatic int low(logic [36:0] r);
      int l;
      l = 0;
      for (int i = 36; i >= 1; i--) if (r[i]) l = i;
      return l;
   endfunction : low

   function automatic logic [31:0] mread(logic [7:0] a);
      logic [36:0] r;
      r = expReq();
      case (a)
         ivm_pkg::FLAG_LO_OFS: return mFlag[31:0];
         ivm_pkg::FLAG_HI_OFS: return {27'h0, mFlag[36:32]};
         ivm_pkg::EN_LO_OFS:   return mEn[31:0];
         ivm_pkg::EN_HI_OFS:   return {27'h0, mEn[36:32]};
         ivm_pkg::CTRL_OFS:    return {29'h0, mCtrl};
         ivm_pkg::PEND_LO_OFS: return r[31:0];
         ivm_pkg::PEND_HI_OFS: return {27'h0, r[36:32]};
         ivm_pkg::VECT_OFS:    return {r != 37'h0, 15'h0,
            8'(2 * low(r)), 8'(low(r))};
         default:              return 32'h0;
      endcase
   endfunction : mread

   function automatic void mwrite(logic [7:0] a, logic [31:0] d,
      logic [3:0] be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      case (a)
         ivm_pkg::FLAG_LO_OFS: mFlag[31:0] &= ~(d & m);
         ivm_pkg::FLAG_HI_OFS: mFlag[36:32] &= ~(d[4:0] & m[4:0]);
         ivm_pkg::EN_LO_OFS:   mEn[31:0] = (mEn[31:0] & ~m) | (d & m);
         ivm_pkg::EN_HI_OFS:   mEn[36:32] = (mEn[36:32] & ~m[4:0])
            | (d[4:0] & m[4:0]);
         ivm_pkg::CTRL_OFS:    if (be[0]) mCtrl = d[2:0];
         default: ;
      endcase
   endfunction : mwrite

   // ----------------------------------------------------------------
   // bus, stimulus and compare tasks
   // ----------------------------------------------------------------
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         numErrors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task automatic bus(input logic rd, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
      @(posedge clock);
      address    <= a;
      read       <= rd;
      write      <= !rd;
      writedata  <= d;
      byteenable <= be;
      do begin
         @(posedge clock);
      end while (waitrequest !== 1'b0);
      q = readdata;
      read  <= 1'b0;
      write <= 1'b0;
      if (!rd) mwrite(a, d, be);
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] be);
      logic [31:0] q;
      bus(1'b0, a, d, be, q);
   endtask : wr

   task automatic rdchk(input logic [7:0] a);
      logic [31:0] q;
      bus(1'b1, a, 32'h0, 4'hF, q);
      cmp(q, mread(a));
   endtask : rdchk

   task automatic clr();
      wr(ivm_pkg::FLAG_LO_OFS, 32'hFFFF_FFFF, 4'hF);
      wr(ivm_pkg::FLAG_HI_OFS, 32'h0000_001F, 4'hF);
   endtask : clr

   task automatic pulse(input logic [36:0] ev, input logic ms,
      input logic cf, input logic [4:0] sp);
      logic [36:0] e;
      @(posedge clock);
      src <= {ms, cf, sp, ev};
      @(posedge clock);
      src <= '0;
      e = ev & ~37'h0_0000_000B;
      if (mCtrl[1]) e = (e & ~37'h0_0000_3E00) | ({32'h0, sp} << 9);
      else e[10] = 1'b0;
      e[1] = ms | (cf & mCtrl[2]);
      e[3] = cf & !mCtrl[2];
      mFlag |= e;
   endtask : pulse

   task automatic check_all();
      logic [36:0] r;
      repeat (3) @(posedge clock);
      r = expReq();
      cmp(reqVec, r);
      cmp(irq, |r[36:2]);
      cmp(nmi, mFlag[1]);
      cmp(vecNum, 64'(low(r)));
      cmp(vecAddr, 64'(2 * low(r)));
      cmp(vecValid, r != 37'h0);
      if (r != 37'h0) cmp(fetchAddr, 64'(2 * low(r)));
      rdchk(ivm_pkg::VECT_OFS);
   endtask : check_all

   task automatic test_done();
      $display("checks %0d errors %0d", checks, numErrors);
      if (numErrors == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   initial begin
      #(8 * 20000);
      numErrors++;
      test_done();
   end

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      address = 8'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      byteenable = 4'h0;
      src = '0;
      mFlag = 37'h0;
      mEn = 37'h0;
      mCtrl = 3'h0;
      void'($urandom(38));
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      cmp(waitrequest, 1'b1);
      for (int a = 0; a <= 32; a += 4) rdchk(8'(a));
      pulse(37'h1F_FFFF_FFFF, 1'b1, 1'b1, 5'h1F);
      check_all();
      rdchk(ivm_pkg::FLAG_LO_OFS);
      rdchk(ivm_pkg::FLAG_HI_OFS);
      wr(ivm_pkg::EN_LO_OFS, 32'hFFFF_FFFF, 4'hF);
      wr(ivm_pkg::EN_HI_OFS, 32'h0000_001F, 4'hF);
      check_all();
      wr(ivm_pkg::CTRL_OFS, 32'h0000_0001, 4'hF);
      check_all();
      wr(ivm_pkg::FLAG_LO_OFS, 32'hFFFF_FFFF, 4'h1);
      wr(ivm_pkg::PEND_LO_OFS, 32'hFFFF_FFFF, 4'hF);
      wr(8'h20, 32'hFFFF_FFFF, 4'hF);
      rdchk(ivm_pkg::FLAG_LO_OFS);
      rdchk(ivm_pkg::PEND_LO_OFS);
      repeat (40) @(posedge clock);
      check_all();
      clr();
      check_all();
      for (int v = 1; v <= 36; v++) begin
         pulse(37'h1 << v, v == 1, v == 3, 5'h0);
         check_all();
         clr();
      end
      wr(ivm_pkg::CTRL_OFS, 32'h0000_0003, 4'hF);
      for (int k = 0; k < 5; k++) begin
         pulse(37'h0_0000_3E00, 1'b0, 1'b0, 5'h01 << k);
         check_all();
         clr();
      end
      wr(ivm_pkg::CTRL_OFS, 32'h0000_0005, 4'hF);
      pulse(37'h0, 1'b0, 1'b1, 5'h0);
      check_all();
      clr();
      for (int i = 0; i < 30; i++) begin
         wr(ivm_pkg::EN_LO_OFS, $urandom(), 4'hF);
         wr(ivm_pkg::CTRL_OFS, $urandom_range(7, 0), 4'hF);
         pulse(37'({$urandom(), $urandom()}), 1'($urandom()),
            1'($urandom()), 5'($urandom()));
         check_all();
         wr(ivm_pkg::FLAG_LO_OFS, $urandom(), 4'($urandom()));
         check_all();
      end
      cmp(fetches > 0, 1'b1);
      test_done();
   end
endmodule : ivm_top_test
